// >>> hw/motor_pwm_timebase_deadtime.sv
// motor pwm time base, special event trigger, pair control and dead time, apb slave
`timescale 1ns/1ps
`include "pwm_params.svh"
module motor_pwm_timebase_deadtime
    import pwm_pkg::*;
#(
    parameter int CNT_W = 15,
    parameter int PAIRS = 4
)
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [2*PAIRS-1:0] pwm_out,
    output logic      [2*PAIRS-1:0] pwm_oe_n,
    output logic                   event_trigger
);
    localparam int DW = 11; // dead gap cycle width: 63 * 32 fits

    // ******************************************
    // registers
    // ******************************************
    logic [CNT_W-1:0]   count_ff;        // timebase_count_value
    logic               dir_ff;          // count_direction_flag, 1 = down
    logic [CNT_W-1:0]   per_buf_ff;      // timebase_period_value as written
    logic [CNT_W-1:0]   per_act_ff;      // period in use
    logic [CNT_W-1:0]   cmp_ff;          // trigger_compare_value
    logic               cmp_dir_ff;      // trigger_direction_select
    logic [PAIRS-1:0]   pair_output_mode_ff;         // pair_output_mode
    logic [PAIRS-1:0]   pen_ff;          // pair_output_enable
    logic [3:0]         trigger_postscale_select_ff;       // trigger_postscale_select
    logic               override_sync_select_ff;        // override_sync_select
    logic               buffer_update_disable_ff;         // buffer_update_disable
    logic [15:0]        dtcon_ff;        // dead time prescales and values
    logic               tb_en_ff;        // timebase_enable_bit
    tb_mode_t           tb_mode_ff;      // timebase_mode_field
    logic [2*PAIRS-1:0] dtsel_ff;        // deadtime_unit_select, rise bit above fall
    logic [2*PAIRS-1:0] povd_ff;         // manual_override_control: 1 = pwm drives
    logic [2*PAIRS-1:0] pout_ff;         // manual_override_control: forced levels
    logic [2*PAIRS-1:0] povd_act_ff;     // override select in use
    logic [2*PAIRS-1:0] pout_act_ff;     // forced levels in use
    logic [15:0]        duty_buf_ff [PAIRS]; // duty as written
    logic [15:0]        duty_act_ff [PAIRS]; // duty in use
    logic [3:0]         post_cnt_ff;     // events seen since last passed trigger
    logic               pready_ff;
    logic [31:0]        prdata_ff;
    logic               pslverr_ff;
    logic [2*PAIRS-1:0] pwm_out_ff;
    logic [2*PAIRS-1:0] pwm_oe_n_ff;
    logic               trig_ff;

    // ******************************************
    // bus decode
    // ******************************************
    logic        acc_first;  // first access cycle, answer being prepared
    logic        wr_go;      // write completes at this edge
    logic [15:0] rd_word;
    logic        addr_hit;

    assign acc_first = psel & penable & ~pready_ff;
    assign wr_go     = psel & penable & pready_ff & pwrite;
    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;

    // read mux; unused bits are zero
    always_comb
    begin
        addr_hit = 1'b1;
        rd_word  = 16'h0000;
        case (paddr)
            `OFS_COUNT:   rd_word = {dir_ff, count_ff};
            `OFS_PERIOD:  rd_word = {1'b0, per_buf_ff};
            `OFS_COMPARE: rd_word = {cmp_dir_ff, cmp_ff};
            `OFS_PAIRCTL: rd_word = {4'h0, pair_output_mode_ff, 4'h0, pen_ff};
            `OFS_TRIGUPD: rd_word = {4'h0, trigger_postscale_select_ff, 6'h00, override_sync_select_ff, buffer_update_disable_ff};
            `OFS_DEADT:   rd_word = dtcon_ff;
            `OFS_TBCTL:   rd_word = {tb_en_ff, 13'h0000, tb_mode_ff};
            `OFS_DTSEL:   rd_word = {8'h00, dtsel_ff};
            `OFS_OVRD:    rd_word = {povd_ff, pout_ff};
            `OFS_DUTY0:   rd_word = duty_buf_ff[0];
            `OFS_DUTY1:   rd_word = duty_buf_ff[1];
            `OFS_DUTY2:   rd_word = duty_buf_ff[2];
            `OFS_DUTY3:   rd_word = duty_buf_ff[3];
            default:      addr_hit = 1'b0;
        endcase
    end

    // one wait state: answer prepared in the first access cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= acc_first;
            if (acc_first)
            begin
                prdata_ff  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
                pslverr_ff <= ~addr_hit;
            end
        end
    end

    // ******************************************
    // time base
    // ******************************************
    logic at_per;    // count sits on the period
    logic updn;      // an up/down mode
    logic boundary;  // end of a pwm period, and also its peak in MODE_UPDN_DBL
    logic upd_ok;    // buffers may be copied now

    assign at_per   = (count_ff == per_act_ff);
    assign updn     = (tb_mode_ff == MODE_UPDN) | (tb_mode_ff == MODE_UPDN_DBL);
    assign boundary = tb_en_ff & ((~updn & at_per) | (updn & dir_ff & count_ff == '0)
                      | (tb_mode_ff == MODE_UPDN_DBL & ~dir_ff & at_per));
    // with the time base off there is no cycle to tear, so copies go straight through
    assign upd_ok   = ~buffer_update_disable_ff & (boundary | ~tb_en_ff);

    // enable and mode; single shot turns itself off at the period
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tb_en_ff   <= 1'b0;
            tb_mode_ff <= MODE_FREE;
        end
        else if (wr_go && paddr == `OFS_TBCTL)
        begin
            tb_en_ff   <= pwdata[`TB_EN_BIT];
            tb_mode_ff <= tb_mode_t'(pwdata[`MODE_LO +: 2]);
        end
        else if (tb_en_ff && tb_mode_ff == MODE_SHOT && at_per)
        begin
            tb_en_ff <= 1'b0;
        end
    end

    // counter and direction; a software write to the count wins
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            count_ff <= '0;
            dir_ff   <= 1'b0;
        end
        else if (wr_go && paddr == `OFS_COUNT)
        begin
            count_ff <= pwdata[CNT_W-1:0];
        end
        else if (tb_en_ff)
        begin
            if (!updn)
            begin
                dir_ff   <= 1'b0;
                count_ff <= at_per ? '0 : count_ff + 1'b1;
            end
            else if (!dir_ff)
            begin
                if (count_ff >= per_act_ff)
                begin
                    dir_ff   <= 1'b1;
                    count_ff <= (count_ff == '0) ? '0 : count_ff - 1'b1;
                end
                else
                    count_ff <= count_ff + 1'b1;
            end
            else if (count_ff == '0)
            begin
                dir_ff   <= 1'b0;
                count_ff <= (per_act_ff == '0) ? '0 : count_ff + 1'b1;
            end
            else
                count_ff <= count_ff - 1'b1;
        end
    end

    // buffered period and duty copied at a boundary, or at once while the time base is off
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            per_act_ff <= '0;
            for (int i = 0; i < PAIRS; i++)
                duty_act_ff[i] <= 16'h0000;
        end
        else if (upd_ok)
        begin
            per_act_ff <= per_buf_ff;
            for (int i = 0; i < PAIRS; i++)
                duty_act_ff[i] <= duty_buf_ff[i];
        end
    end

    // ******************************************
    // software settings
    // ******************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            per_buf_ff <= '0;
            cmp_ff     <= '0;
            cmp_dir_ff <= 1'b0;
            pair_output_mode_ff    <= '0;
            pen_ff     <= `PEN_RST;
            trigger_postscale_select_ff  <= 4'h0;
            override_sync_select_ff   <= 1'b0;
            buffer_update_disable_ff    <= 1'b0;
            dtcon_ff   <= 16'h0000;
            dtsel_ff   <= '0;
            povd_ff    <= `POVD_RST;
            pout_ff    <= '0;
            for (int i = 0; i < PAIRS; i++)
                duty_buf_ff[i] <= 16'h0000;
        end
        else if (wr_go)
        begin
            case (paddr)
                `OFS_PERIOD:  per_buf_ff <= pwdata[CNT_W-1:0];
                `OFS_COMPARE:
                begin
                    cmp_ff     <= pwdata[CNT_W-1:0];
                    cmp_dir_ff <= pwdata[`DIR_BIT];
                end
                `OFS_PAIRCTL:
                begin
                    pair_output_mode_ff <= pwdata[`PAIR_OUTPUT_MODE_LO +: PAIRS];
                    pen_ff  <= pwdata[`PEN_LO +: PAIRS];
                end
                `OFS_TRIGUPD:
                begin
                    trigger_postscale_select_ff <= pwdata[`TRIGGER_POSTSCALE_SELECT_LO +: 4];
                    override_sync_select_ff  <= pwdata[`OVERRIDE_SYNC_SELECT_BIT];
                    buffer_update_disable_ff   <= pwdata[`BUFFER_UPDATE_DISABLE_BIT];
                end
                `OFS_DEADT:   dtcon_ff <= pwdata[15:0];
                `OFS_DTSEL:   dtsel_ff <= pwdata[2*PAIRS-1:0];
                `OFS_OVRD:
                begin
                    povd_ff <= pwdata[`POVD_LO +: 2*PAIRS];
                    pout_ff <= pwdata[2*PAIRS-1:0];
                end
                `OFS_DUTY0:   duty_buf_ff[0] <= pwdata[15:0];
                `OFS_DUTY1:   duty_buf_ff[1] <= pwdata[15:0];
                `OFS_DUTY2:   duty_buf_ff[2] <= pwdata[15:0];
                `OFS_DUTY3:   duty_buf_ff[3] <= pwdata[15:0];
                default:      ;
            endcase
        end
    end

    // ******************************************
    // special event trigger and postscaler
    // ******************************************
    logic       sev_hit;
    logic [3:0] post_lim;  // last hit count before one passes

    assign sev_hit       = tb_en_ff & (count_ff == cmp_ff) & (dir_ff == cmp_dir_ff);
    // 1110 is the one code off the linear ladder: it passes one in 8
    assign post_lim      = (trigger_postscale_select_ff == 4'hE) ? 4'h7 : trigger_postscale_select_ff;
    assign event_trigger = trig_ff;

    // passes one hit in every post_lim + 1
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            post_cnt_ff <= 4'h0;
            trig_ff     <= 1'b0;
        end
        else if (sev_hit)
        begin
            trig_ff     <= (post_cnt_ff >= post_lim);
            post_cnt_ff <= (post_cnt_ff >= post_lim) ? 4'h0 : post_cnt_ff + 4'h1;
        end
        else
            trig_ff <= 1'b0;
    end

    // ******************************************
    // overrides
    // ******************************************
    // unsynced overrides follow one clock after the write; synced ones wait for the boundary
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            povd_act_ff <= `POVD_RST;
            pout_act_ff <= '0;
        end
        else if (!override_sync_select_ff || boundary)
        begin
            povd_act_ff <= povd_ff;
            pout_act_ff <= pout_ff;
        end
    end

    // ******************************************
    // dead time and pins
    // ******************************************
    dt_cfg_t          dt_a;
    dt_cfg_t          dt_b;
    logic [DW-1:0]    dt_a_cycles;  // unit A gap in clocks
    logic [DW-1:0]    dt_b_cycles;  // unit B gap in clocks
    pin_pair_t        drive [PAIRS];

    assign dt_a        = '{prescale: dtcon_ff[`DTA_PS_LO +: 2], value: dtcon_ff[`DTA_VAL_LO +: 6]};
    assign dt_b        = '{prescale: dtcon_ff[`DTB_PS_LO +: 2], value: dtcon_ff[`DTB_VAL_LO +: 6]};
    // a prescaled tick of 4 << ps clocks, so the gap is value times that period
    assign dt_a_cycles = {5'h00, dt_a.value} << (`DT_PS_BASE + {1'b0, dt_a.prescale});
    assign dt_b_cycles = {5'h00, dt_b.value} << (`DT_PS_BASE + {1'b0, dt_b.prescale});

    generate
        for (genvar g = 0; g < PAIRS; g++)
        begin : g_pair
            dead_time_unit #(.CW(DW)) u_dt
            (
                .clk         (clk),
                .sys_rst     (sys_rst),
                .pwm_raw     ({1'b0, count_ff} < duty_act_ff[g]),
                .indep       (pair_output_mode_ff[g]),
                .rise_cycles (dtsel_ff[2*g+1] ? dt_b_cycles : dt_a_cycles),
                .fall_cycles (dtsel_ff[2*g] ? dt_b_cycles : dt_a_cycles),
                .drive       (drive[g])
            );
        end
    endgenerate

    assign pwm_out  = pwm_out_ff;
    assign pwm_oe_n = pwm_oe_n_ff;

    // disabled pairs release their pins to general-purpose use
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pwm_out_ff  <= '0;
            pwm_oe_n_ff <= '1;
        end
        else
        begin
            for (int i = 0; i < PAIRS; i++)
            begin
                pwm_oe_n_ff[2*i +: 2] <= pen_ff[i] ? 2'b00 : 2'b11;
                pwm_out_ff[2*i]       <= pen_ff[i] & (povd_act_ff[2*i] ? drive[i].hi : pout_act_ff[2*i]);
                pwm_out_ff[2*i+1]     <= pen_ff[i] & (povd_act_ff[2*i+1] ? drive[i].lo : pout_act_ff[2*i+1]);
            end
        end
    end

    // ******************************************
    // checks
    // ******************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_rd_count;
        acc_first && !pwrite && paddr == `OFS_COUNT;
    endsequence
    sequence s_wr_count;
        wr_go && paddr == `OFS_COUNT;
    endsequence
    property p_dir_read;
        s_rd_count |=> prdata_ff[15] == $past(dir_ff) && pready_ff;
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction flag not in read data");
    property p_count_write;
        s_wr_count |=> count_ff == $past(pwdata[CNT_W-1:0]);
    endproperty
    a_count_write: assert property (p_count_write) else $error("count write lost");
    property p_upper_zero;
        pready_ff |-> prdata_ff[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
    property p_trig_cause;
        trig_ff |-> $past(count_ff == cmp_ff && dir_ff == cmp_dir_ff && tb_en_ff);
    endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger without qualified match");
    property p_post_one;
        sev_hit && trigger_postscale_select_ff == 4'h0 |=> trig_ff;
    endproperty
    a_post_one: assert property (p_post_one) else $error("1:1 postscale dropped an event");
    property p_override_sync_select_off;
        !override_sync_select_ff |=> povd_act_ff == $past(povd_ff);
    endproperty
    a_override_sync_select_off: assert property (p_override_sync_select_off) else $error("unsynced override not applied");
    property p_buffer_update_disable_hold;
        buffer_update_disable_ff |=> per_act_ff == $past(per_act_ff);
    endproperty
    a_buffer_update_disable_hold: assert property (p_buffer_update_disable_hold) else $error("period copied while disabled");
    property p_tb_off;
        !tb_en_ff && !wr_go |=> count_ff == $past(count_ff);
    endproperty
    a_tb_off: assert property (p_tb_off) else $error("time base moved while off");
    property p_free_wrap;
        tb_en_ff && tb_mode_ff == MODE_FREE && at_per && !wr_go |=> count_ff == '0;
    endproperty
    a_free_wrap: assert property (p_free_wrap) else $error("free running count missed wrap");
    property p_pair_off;
        !pen_ff[0] |=> pwm_oe_n_ff[1:0] == 2'b11 && pwm_out_ff[1:0] == 2'b00;
    endproperty
    a_pair_off: assert property (p_pair_off) else $error("disabled pair still driven");
    property p_copy_at_end;
        boundary && !buffer_update_disable_ff |=> per_act_ff == $past(per_buf_ff);
    endproperty
    a_copy_at_end: assert property (p_copy_at_end) else $error("period not copied at boundary");
endmodule : motor_pwm_timebase_deadtime

// >>> hw/pwm_params.svh
// offsets, field positions, reset values and dead-time prescale timing of the motor pwm block
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH
// ******************************************
// register byte offsets (one aligned word each)
// ******************************************
`define OFS_COUNT    8'h00
`define OFS_PERIOD   8'h04
`define OFS_COMPARE  8'h08
`define OFS_PAIRCTL  8'h0C
`define OFS_TRIGUPD  8'h10
`define OFS_DEADT    8'h14
`define OFS_TBCTL    8'h18
`define OFS_DTSEL    8'h1C
`define OFS_OVRD     8'h20
`define OFS_DUTY0    8'h24
`define OFS_DUTY1    8'h28
`define OFS_DUTY2    8'h2C
`define OFS_DUTY3    8'h30
// ******************************************
// field positions
// ******************************************
`define DIR_BIT      15
`define TB_EN_BIT    15
`define MODE_LO      0
`define PAIR_OUTPUT_MODE_LO      8
`define PEN_LO       0
`define TRIGGER_POSTSCALE_SELECT_LO    8
`define OVERRIDE_SYNC_SELECT_BIT    1
`define BUFFER_UPDATE_DISABLE_BIT     0
`define DTB_PS_LO    14
`define DTB_VAL_LO   8
`define DTA_PS_LO    6
`define DTA_VAL_LO   0
`define POVD_LO      8
// ******************************************
// reset values and timing
// ******************************************
`define PEN_RST      4'hF
`define POVD_RST     8'hFF
`define DT_PS_BASE   3'h2
`endif

// >>> hw/pwm_pkg.sv
// types shared by the motor pwm block and its dead-time units
package pwm_pkg;
    // time-base counting modes
    typedef enum logic [1:0]
    {
        MODE_FREE     = 2'b00,
        MODE_SHOT     = 2'b01,
        MODE_UPDN     = 2'b10,
        MODE_UPDN_DBL = 2'b11
    } tb_mode_t;
    // dead-time unit state, gray coded
    typedef enum logic [1:0]
    {
        DT_RUN  = 2'b00,
        DT_DEAD = 2'b01
    } dt_state_t;
    // one dead-time unit's settings
    typedef struct packed
    {
        logic [1:0] prescale;
        logic [5:0] value;
    } dt_cfg_t;
    // drive pair for one pin pair
    typedef struct packed
    {
        logic hi;
        logic lo;
    } pin_pair_t;
endpackage : pwm_pkg

// >>> hw/dead_time_unit.sv
// dead-time insertion for one complementary pwm pin pair
`timescale 1ns/1ps
`include "pwm_params.svh"
module dead_time_unit
    import pwm_pkg::*;
#(
    parameter int CW = 11
)
(
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          pwm_raw,
    input  wire logic          indep,
    input  wire logic [CW-1:0] rise_cycles,
    input  wire logic [CW-1:0] fall_cycles,
    output pin_pair_t          drive
);
    logic          raw_d_ff;   // last raw level, for edge detection
    dt_state_t     state_ff;   // running or inside a dead gap
    dt_state_t     nxt_state;
    logic [CW-1:0] cnt_ff;     // cycles of gap still to run
    logic [CW-1:0] nxt_cnt;
    logic          edge_seen;
    logic [CW-1:0] gap;

    // ******************************************
    // gap sequencing
    // ******************************************
    // a new edge restarts the gap, so a short pulse never lets both switches on
    always_comb
    begin
        edge_seen = pwm_raw ^ raw_d_ff;
        gap       = pwm_raw ? rise_cycles : fall_cycles;
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        if (indep)
        begin
            nxt_state = DT_RUN;
        end
        else if (edge_seen && gap != '0)
        begin
            nxt_state = DT_DEAD;
            nxt_cnt   = gap;
        end
        else if (state_ff == DT_DEAD)
        begin
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == 1)
                nxt_state = DT_RUN;
        end
    end

    // state registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            raw_d_ff <= 1'b0;
            state_ff <= DT_RUN;
            cnt_ff   <= '0;
        end
        else
        begin
            raw_d_ff <= pwm_raw;
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // outputs: both low during a gap, copies of raw when independent
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            drive <= '0;
        else if (indep)
            drive <= '{hi: pwm_raw, lo: pwm_raw};
        else
            drive <= '{hi: (nxt_state == DT_RUN) & pwm_raw, lo: (nxt_state == DT_RUN) & ~pwm_raw};
    end

    // ******************************************
    // checks
    // ******************************************
    property p_no_overlap;
        @(posedge clk) disable iff (sys_rst) !indep && !$past(indep) |-> !(drive.hi && drive.lo);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both switches of a pair on");
    property p_gap_held;
        @(posedge clk) disable iff (sys_rst)
            (!indep && $rose(pwm_raw) && rise_cycles == 11'h004) |=> !drive.hi [*4];
    endproperty
    a_gap_held: assert property (p_gap_held) else $error("dead gap shorter than set");
endmodule : dead_time_unit

// >>> tb/switch_bridge_model.sv
// inverter switch legs driven by the pwm pin pairs
`timescale 1ns/1ps
module switch_bridge_model
(
    input  wire logic [7:0] gate_level,
    input  wire logic [7:0] gate_oe_n,
    output logic      [3:0] leg_short
);
    // ****************
    // shoot-through
    // ****************
    // a released gate pin sits on its pull-down, so only driven highs turn a switch on
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            leg_short[i] = !gate_oe_n[2*i] && !gate_oe_n[2*i+1] && gate_level[2*i] && gate_level[2*i+1];
        end
    end
endmodule : switch_bridge_model

// >>> tb/tb.sv
// self-checking bench for the motor pwm block
`timescale 1ns/1ps
`include "pwm_params.svh"
module tb;
    logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, d;
    logic        pready, pslverr, event_trigger;
    logic [7:0]  pwm_out, pwm_oe_n;
    logic [3:0]  leg_short;
    logic [32:0] exp_q[$];  // expected {error, data} of each read, oldest first
    int          fails = 0, total_checks = 0, seed = 99054, on_cycles;
    int          codes[3] = '{1, 14, 15};
    always #25 clk = ~clk;
    motor_pwm_timebase_deadtime uut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .event_trigger(event_trigger));
    switch_bridge_model bridge (.gate_level(pwm_out), .gate_oe_n(pwm_oe_n), .leg_short(leg_short));
    // ****************
    // checking
    // ****************
    task automatic chk(input logic [32:0] seen, input logic [32:0] want);
        total_checks++;
        if (seen !== want)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // watcher: each completed read is matched against the oldest note; legs must never short
    always @(posedge clk)
    begin
        if (pready === 1'b1 && pwrite === 1'b0)
            chk({pslverr, prdata}, exp_q.pop_front());
        if (sys_rst === 1'b0 && leg_short !== 4'h0)
            chk({29'h0, leg_short}, 33'h0);
    end
    // ****************
    // apb master
    // ****************
    // request held until pready is seen high at a rising edge, then released
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        int n;
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            chk(33'h1, 33'h0);
            complete_run();
        end
        else
        begin
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(a, 1'b1, wd);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] want);
        exp_q.push_back(want);
        apb(a, 1'b0, 32'h0);
    endtask : rd
    // distance between two trigger pulses, capped so a silent trigger reads as the cap
    task automatic spacing(input int want);
        int n;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (event_trigger !== 1'b1 && n < 600);
        end
        chk(n, want);
    endtask : spacing
    // ****************
    // scenarios
    // ****************
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`OFS_PAIRCTL, 33'h0000F);
        rd(`OFS_TRIGUPD, 33'h0);
        wr(`OFS_COUNT, 32'h0000_7FFF);
        rd(`OFS_COUNT, 33'h07FFF);
        wr(`OFS_PERIOD, 32'h0000_7FFF);
        rd(`OFS_PERIOD, 33'h07FFF);
        wr(`OFS_PAIRCTL, 32'h0000_0F0F);
        rd(`OFS_PAIRCTL, 33'h00F0F);
        wr(`OFS_TRIGUPD, 32'h0000_0F03);
        rd(`OFS_TRIGUPD, 33'h00F03);
        rd(8'h40, 33'h1_0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            d = $random(seed);
            wr(`OFS_COMPARE, {16'h0, d[15:0]});
            rd(`OFS_COMPARE, {17'h0, d[15:0]});
            wr(`OFS_DEADT, {16'h0, d[31:16]});
            rd(`OFS_DEADT, {17'h0, d[31:16]});
        end
        // disabled pairs are released to general-purpose use
        wr(`OFS_PAIRCTL, 32'h0);
        repeat (3) @(posedge clk);
        chk(pwm_oe_n, 33'hFF);
        wr(`OFS_PAIRCTL, 32'h000F);
        repeat (3) @(posedge clk);
        chk(pwm_oe_n, 33'h00);
        // free-running time base, period 9 gives ten counts per cycle
        wr(`OFS_TRIGUPD, 32'h0);
        wr(`OFS_DEADT, 32'h0101);
        wr(`OFS_DUTY0, 32'h5);
        wr(`OFS_PERIOD, 32'h9);
        wr(`OFS_COUNT, 32'h0);
        wr(`OFS_COMPARE, 32'h3);
        wr(`OFS_TBCTL, 32'h8000);
        spacing(10);
        // one clock per side: five raw high counts less a gap of 1 x 4 clocks
        on_cycles = 0;
        repeat (10)
        begin
            @(posedge clk);
            on_cycles = on_cycles + pwm_out[0] + pwm_out[1];
        end
        chk(on_cycles, 2);
        // an unsynced forced level reaches the pins without waiting for the period
        wr(`OFS_OVRD, 32'h0000_FC01);
        repeat (2) @(posedge clk);
        chk(pwm_out[1:0], 33'h1);
        wr(`OFS_OVRD, 32'h0000_FF00);
        foreach (codes[i])
        begin
            wr(`OFS_TRIGUPD, codes[i] << 8);
            spacing((codes[i] == 14) ? 80 : (codes[i] + 1) * 10);
        end
        wr(`OFS_TRIGUPD, 32'h0);
        wr(`OFS_COMPARE, 32'h8003);
        spacing(600);
        // stopped time base keeps a written count
        wr(`OFS_TBCTL, 32'h0);
        wr(`OFS_COUNT, 32'h5);
        repeat (5) @(posedge clk);
        rd(`OFS_COUNT, 33'h5);
        wr(`OFS_TBCTL, 32'h8002);
        spacing(18);
        complete_run();
    end
endmodule : tb
